/* File: hw/irq_option_ctrl.sv */
// interrupt flags, enables and option configuration with wishbone slave
`timescale 1ns/1ps
`include "irq_option_regs.svh"
module irq_option_ctrl
   import irq_option_pkg::*;
(
   // clock and reset
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   // wishbone slave
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic [31:0]        wb_dat_o,
   output logic               wb_ack_o,
   // pins
   input  wire logic          external_irq_pin_i,
   input  wire logic          timer_zero_clock_pin_i,
   input  wire logic [7:0]    portb_pins_i,
   // port B output latch values
   input  wire logic [7:0]    portb_latch_i,
   // on-chip event pulses
   input  wire logic          timer_zero_overflow_i,
   input  wire periph_evt_t   periph_evt_i,
   input  wire capcomp_mode_t capcomp_mode_i,
   input  wire logic          watchdog_src_i,
   // outputs to core, timers and port
   output logic               irq_o,
   output logic [7:0]         portb_pullup_en_o,
   output logic               timer_zero_tick_o,
   output logic               watchdog_tick_o
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [9:0] sync1_q;
   logic [9:0] sync2_q;
   logic [9:0] sync3_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= 10'h000;
         sync2_q <= 10'h000;
         sync3_q <= 10'h000;
      end else begin
         sync1_q <= {timer_zero_clock_pin_i,
                     external_irq_pin_i,
                     portb_pins_i};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   option_t    option_q, option_d;
   logic [7:0] intctl_q, intctl_d;
   logic [7:0] pen_q, pen_d;
   logic [7:0] preq_q, preq_d;
   logic [7:0] chg_en_q, chg_en_d;
   logic [7:0] pull_q, pull_d;
   logic       irq_q, irq_d;

   bus_state_t bus_q, bus_d;
   logic       ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;

   logic       req;
   logic       wr;
   logic [7:0] rbyte;
   logic       ext_rise;
   logic       ext_fall;
   logic       ext_evt;
   logic       t0_rise;
   logic       t0_fall;
   logic       t0_pin_evt;
   logic       t0_src;
   logic [7:0] pin_diff;
   logic       chg_evt;
   logic       cc_evt;
   logic [7:0] pevt;
   logic       core_pend;
   logic       periph_pend;

   ////////////////////////////////////////////////////////////////////////
   // event detection

   always_comb begin
      ext_rise = sync2_q[8] && !sync3_q[8];
      ext_fall = !sync2_q[8] && sync3_q[8];
      ext_evt  = option_q.ext_irq_edge_select ? ext_rise
                                              : ext_fall;
      t0_rise  = sync2_q[9] && !sync3_q[9];
      t0_fall  = !sync2_q[9] && sync3_q[9];
      t0_pin_evt = option_q.timer_zero_edge_select ? t0_fall
                                                   : t0_rise;
      // internal source counts every instruction cycle
      t0_src   = option_q.timer_zero_clock_select ? t0_pin_evt
                                                  : 1'h1;
      // only pins whose change enable is set can raise the flag
      pin_diff = (sync2_q[7:0] ^ sync3_q[7:0]) & chg_en_q;
      chg_evt  = |pin_diff;
      cc_evt   = (capcomp_mode_i == CC_CAPTURE
                  && periph_evt_i.capcomp_capture)
              || (capcomp_mode_i == CC_COMPARE
                  && periph_evt_i.capcomp_compare);
      pevt = 8'h00;
      pevt[`BIT_CONV]    = periph_evt_i.converter_done;
      pevt[`BIT_CAPCOMP] = cc_evt;
      pevt[`BIT_T2]      = periph_evt_i.timer_two_match;
      pevt[`BIT_T1]      = periph_evt_i.timer_one_overflow;
   end

   ////////////////////////////////////////////////////////////////////////
   // wishbone slave

   always_comb begin
      req   = wb_cyc_i && wb_stb_i;
      wr    = (bus_q == BUS_ACK) && req && wb_we_i && wb_sel_i[0];
      bus_d = BUS_IDLE;
      case (bus_q)
         BUS_IDLE: begin
            if (req) begin
               bus_d = BUS_ACK;
            end
         end
         BUS_ACK: begin
            bus_d = BUS_IDLE;
         end
         default: begin
            bus_d = BUS_IDLE;
         end
      endcase
      ack_d = (bus_d == BUS_ACK);
      // unmapped offsets answer with zero
      if (wb_adr_i == `OFS_OPTION) begin
         rbyte = option_q;
      end else if (wb_adr_i == `OFS_INT_CTRL) begin
         rbyte = intctl_q;
      end else if (wb_adr_i == `OFS_PERIPH_EN) begin
         rbyte = pen_q;
      end else if (wb_adr_i == `OFS_PERIPH_REQ) begin
         rbyte = preq_q;
      end else if (wb_adr_i == `OFS_PIN_CHG_EN) begin
         rbyte = chg_en_q;
      end else begin
         rbyte = 8'h00;
      end
      rdat_d = (bus_q == BUS_IDLE && req) ? {24'h000000, rbyte}
                                          : 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////
   // register next values

   always_comb begin
      option_d = option_q;
      pen_d    = pen_q;
      chg_en_d = chg_en_q;
      intctl_d = intctl_q;
      preq_d   = preq_q;
      if (wr && wb_adr_i == `OFS_OPTION) begin
         option_d = wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `OFS_PERIPH_EN) begin
         pen_d = wb_dat_i[7:0] & `PERIPH_MASK;
      end
      if (wr && wb_adr_i == `OFS_PIN_CHG_EN) begin
         chg_en_d = wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `OFS_INT_CTRL) begin
         intctl_d = wb_dat_i[7:0];
      end
      if (wr && wb_adr_i == `OFS_PERIPH_REQ) begin
         preq_d = wb_dat_i[7:0] & `PERIPH_MASK;
      end
      // events set flags regardless of interrupt enables; set beats a clear
      intctl_d[`BIT_T0_FLAG]  = intctl_d[`BIT_T0_FLAG]
                                | timer_zero_overflow_i;
      intctl_d[`BIT_EXT_FLAG] = intctl_d[`BIT_EXT_FLAG] | ext_evt;
      intctl_d[`BIT_CHG_FLAG] = intctl_d[`BIT_CHG_FLAG] | chg_evt;
      preq_d = preq_d | pevt;
      // pull-ups on only where the latch is high and not disabled
      pull_d = option_q.portb_pullup_disable ? 8'h00
                                             : portb_latch_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // request to the core

   always_comb begin
      core_pend = (intctl_q[`BIT_T0_EN] && intctl_q[`BIT_T0_FLAG])
               || (intctl_q[`BIT_EXT_EN] && intctl_q[`BIT_EXT_FLAG])
               || (intctl_q[`BIT_CHG_EN]
                   && intctl_q[`BIT_CHG_FLAG]);
      periph_pend = intctl_q[`BIT_PERIPH_EN]
                    && |(pen_q & preq_q);
      irq_d = intctl_q[`BIT_GLOBAL_EN]
              && (core_pend || periph_pend);
   end

   ////////////////////////////////////////////////////////////////////////
   // flops

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         option_q <= `RST_OPTION;
         intctl_q <= `RST_INT_CTRL;
         pen_q    <= `RST_PERIPH;
         preq_q   <= `RST_PERIPH;
         chg_en_q <= `RST_PIN_CHG_EN;
         pull_q   <= 8'h00;
         irq_q    <= 1'h0;
         bus_q    <= BUS_IDLE;
         ack_q    <= 1'b0;
         rdat_q   <= 32'h00000000;
      end else begin
         option_q <= option_d;
         intctl_q <= intctl_d;
         pen_q    <= pen_d;
         preq_q   <= preq_d;
         chg_en_q <= chg_en_d;
         pull_q   <= pull_d;
         irq_q    <= irq_d;
         bus_q    <= bus_d;
         ack_q    <= ack_d;
         rdat_q   <= rdat_d;
      end
   end

   assign wb_ack_o          = ack_q;
   assign wb_dat_o          = rdat_q;
   assign irq_o             = irq_q;
   assign portb_pullup_en_o = pull_q;

   ////////////////////////////////////////////////////////////////////////
   // prescaler; the timer zero count itself lives outside and is not
   // touched by this block's reset

   shared_prescaler u_prescaler (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .t0_src_i   (t0_src),
      .wdt_src_i  (watchdog_src_i),
      .assign_i   (option_q.prescaler_assign),
      .rate_i     (option_q.prescale_rate),
      .t0_tick_o  (timer_zero_tick_o),
      .wdt_tick_o (watchdog_tick_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_t0_flag_sets: assert property (
      timer_zero_overflow_i |=> intctl_q[`BIT_T0_FLAG])
      else $error("timer zero flag missed an overflow");

   a_ext_edge_sel: assert property (
      (option_q.ext_irq_edge_select && sync2_q[8] && !sync3_q[8])
      |=> intctl_q[`BIT_EXT_FLAG])
      else $error("external flag missed selected edge");

   a_chg_needs_en: assert property (
      (!intctl_q[`BIT_CHG_FLAG] && chg_en_q == 8'h00 && !wr)
      |=> !intctl_q[`BIT_CHG_FLAG])
      else $error("port change flag set with no pin enabled");

   a_global_block: assert property (
      !intctl_q[`BIT_GLOBAL_EN] |=> !irq_o)
      else $error("request passed with global enable low");

   a_periph_gate: assert property (
      (!intctl_q[`BIT_PERIPH_EN] && !core_pend) |=> !irq_o)
      else $error("peripheral request passed without peripheral enable");

   a_req_formula: assert property (
      (intctl_q[`BIT_GLOBAL_EN] && intctl_q[`BIT_PERIPH_EN]
       && |(pen_q & preq_q)) |=> irq_o)
      else $error("enabled peripheral flag raised no request");

   a_pullup_off: assert property (
      option_q.portb_pullup_disable |=> portb_pullup_en_o == 8'h00)
      else $error("pull-ups on while disabled");

   a_conv_flag: assert property (
      periph_evt_i.converter_done |=> preq_q[`BIT_CONV])
      else $error("converter flag missed completion");

   a_capcomp_pwm: assert property (
      (capcomp_mode_i == CC_PWM && !wr && !preq_q[`BIT_CAPCOMP])
      |=> !preq_q[`BIT_CAPCOMP])
      else $error("capcomp flag set in pwm mode");

   a_timer_flags: assert property (
      periph_evt_i.timer_two_match |=> preq_q[`BIT_T2])
      else $error("timer two flag missed a match");

   a_t1_flag: assert property (
      periph_evt_i.timer_one_overflow |=> preq_q[`BIT_T1])
      else $error("timer one flag missed an overflow");

   a_bus_answer: assert property (
      (req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not a single cycle after request");

   a_ext_fall_sel: assert property (
      (!option_q.ext_irq_edge_select && !sync2_q[8] && sync3_q[8])
      |=> intctl_q[`BIT_EXT_FLAG])
      else $error("external flag missed falling edge");

   a_flag_sticky: assert property (
      (intctl_q[`BIT_T0_FLAG] && !wr) |=> intctl_q[`BIT_T0_FLAG])
      else $error("timer zero flag dropped without a write");

   a_chg_flag_sets: assert property (
      (|pin_diff) |=> intctl_q[`BIT_CHG_FLAG])
      else $error("port change flag missed an enabled pin change");

   a_pullup_follow: assert property (
      !option_q.portb_pullup_disable
      |=> portb_pullup_en_o == $past(portb_latch_i))
      else $error("pull-ups do not follow the port latch");

   a_periph_mask: assert property (
      (pen_q & ~`PERIPH_MASK) == 8'h00
      && (preq_q & ~`PERIPH_MASK) == 8'h00)
      else $error("unimplemented peripheral bit is set");

   a_core_request: assert property (
      (intctl_q[`BIT_GLOBAL_EN] && intctl_q[`BIT_EXT_EN]
       && intctl_q[`BIT_EXT_FLAG]) |=> irq_o)
      else $error("enabled external flag raised no request");

   a_cc_capture: assert property (
      (capcomp_mode_i == CC_CAPTURE && periph_evt_i.capcomp_capture)
      |=> preq_q[`BIT_CAPCOMP])
      else $error("capcomp flag missed a capture");

   a_idle_data: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data driven outside an answer");

endmodule : irq_option_ctrl

/* File: inc/irq_option_regs.svh */
// register offsets, field positions and reset values of the irq/option block
//
// Notes on behaviour
// - option bit 7 high disables all port B pull-ups; low follows latch
// - edge select bit 6: 1 rising, 0 falling edge on external irq pin
// - clock select bit 5: 1 counts timer zero pin, 0 instruction clock
// - edge select bit 4: 1 counts falling, 0 rising edges of timer pin
// - assign bit 3: 1 prescaler to watchdog, 0 to timer zero
// - rate 000..111: timer zero 1:2..1:256, watchdog 1:1..1:128
// - every flag sets on its event whatever the interrupt and peripheral enables say
// - global enable 1 passes unmasked requests, 0 blocks them all
// - peripheral enable gates all peripheral sources with their own enable
// - timer zero overflow flag sets on rollover, sticky; enable bit 5
// - external flag sets on selected pin edge, sticky; enable bit 4
// - port change flag sets when a port B pin changes, sticky; enable bit 3
// - port change also needs the per-pin change enables
// - reset leaves the timer zero count alone; software sets it first
// - converter flag sets on conversion done, else reads 0
// - capcomp flag: capture or compare event per mode, unused in pwm
// - timer two flag sets on period match, sticky
// - timer one flag sets on overflow, sticky
// - peripheral enables: converter 6, capcomp 2, timer two 1, timer one 0
`ifndef IRQ_OPTION_REGS_SVH
`define IRQ_OPTION_REGS_SVH

`define OFS_OPTION      8'h00
`define OFS_INT_CTRL    8'h04
`define OFS_PERIPH_EN   8'h08
`define OFS_PERIPH_REQ  8'h0C
`define OFS_PIN_CHG_EN  8'h10

`define RST_OPTION      8'hFF
`define RST_INT_CTRL    8'h00
`define RST_PERIPH      8'h00
`define RST_PIN_CHG_EN  8'h00
`define PERIPH_MASK     8'h47

`define BIT_GLOBAL_EN   7
`define BIT_PERIPH_EN   6
`define BIT_T0_EN       5
`define BIT_EXT_EN      4
`define BIT_CHG_EN      3
`define BIT_T0_FLAG     2
`define BIT_EXT_FLAG    1
`define BIT_CHG_FLAG    0

`define BIT_CONV        6
`define BIT_CAPCOMP     2
`define BIT_T2          1
`define BIT_T1          0

`endif

/* File: inc/irq_option_pkg.sv */
// types shared by the irq/option block
package irq_option_pkg;

   typedef struct packed {
      logic       portb_pullup_disable;
      logic       ext_irq_edge_select;
      logic       timer_zero_clock_select;
      logic       timer_zero_edge_select;
      logic       prescaler_assign;
      logic [2:0] prescale_rate;
   } option_t;

   typedef struct packed {
      logic converter_done;
      logic capcomp_capture;
      logic capcomp_compare;
      logic timer_two_match;
      logic timer_one_overflow;
   } periph_evt_t;

   typedef enum logic [1:0] {
      CC_OFF     = 2'h0,
      CC_CAPTURE = 2'h1,
      CC_COMPARE = 2'h2,
      CC_PWM     = 2'h3
   } capcomp_mode_t;

   typedef enum logic {
      BUS_IDLE = 1'h0,
      BUS_ACK  = 1'h1
   } bus_state_t;

endpackage : irq_option_pkg

/* File: hw/shared_prescaler.sv */
// shared prescaler between timer zero and watchdog
`timescale 1ns/1ps
module shared_prescaler (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // sources
   input  wire logic       t0_src_i,
   input  wire logic       wdt_src_i,
   // setup
   input  wire logic       assign_i,
   input  wire logic [2:0] rate_i,
   // scaled ticks
   output logic            t0_tick_o,
   output logic            wdt_tick_o
);
   logic [7:0] cnt_q, cnt_d;
   logic       t0_q, t0_d;
   logic       wdt_q, wdt_d;
   logic       src;
   logic [7:0] mask;
   logic       hit;

   always_comb begin
      // the one counter follows whichever source it is attached to
      src  = assign_i ? wdt_src_i : t0_src_i;
      // timer zero divides by 2^(n+1), the watchdog by 2^n
      mask = assign_i ? 8'((9'h001 << rate_i) - 9'h001)
                      : 8'((9'h002 << rate_i) - 9'h001);
      hit  = src && ((cnt_q & mask) == mask);
      cnt_d = src ? 8'(cnt_q + 8'h01) : cnt_q;
      t0_d  = assign_i ? t0_src_i : hit;
      wdt_d = assign_i ? hit : wdt_src_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q <= 8'h00;
         t0_q  <= 1'h0;
         wdt_q <= 1'h0;
      end else begin
         cnt_q <= cnt_d;
         t0_q  <= t0_d;
         wdt_q <= wdt_d;
      end
   end

   assign t0_tick_o  = t0_q;
   assign wdt_tick_o = wdt_q;

endmodule : shared_prescaler

/* File: bench/evt_source_model.sv */
// behavioural timer and peripheral event sources facing the irq block
`timescale 1ns/1ps
module evt_source_model
   import irq_option_pkg::*;
(
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // requests from the bench
   input  wire logic [5:0] fire_i,
   input  wire logic       wdt_run_i,
   // events
   output logic            t0_ovf_o,
   output periph_evt_t     evt_o,
   output logic            wdt_src_o
);
   ////////////////////////////////////////////////////////////////////////
   // single-cycle pulses, as a counter wrap or a finished conversion gives
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         t0_ovf_o  <= 1'h0;
         evt_o     <= '0;
         wdt_src_o <= 1'h0;
      end else begin
         t0_ovf_o  <= fire_i[5];
         evt_o     <= fire_i[4:0];
         wdt_src_o <= wdt_run_i;
      end
   end
endmodule : evt_source_model

/* File: bench/tb_irq_option_ctrl.sv */
// register-level testbench of the irq/option block
`timescale 1ns/1ps
`include "irq_option_regs.svh"
module tb_irq_option_ctrl
   import irq_option_pkg::*;
;
   logic          clk_i = 1'h0;
   logic          rst_i = 1'h1;
   logic          cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic [7:0]    adr = 8'h00, ext = 8'h00, pb = 8'h00, lat = 8'h00;
   logic [31:0]   wdat = 32'h0, dat_o, rd;
   logic          ack, irq, t0tick, wdtick, t0ovf, wdsrc, tpin = 1'h0;
   logic [5:0]    fire = 6'h00;
   logic          wrun = 1'h0;
   logic [3:0]    sel = 4'h0, wsel = 4'hF;
   logic [7:0]    pull;
   periph_evt_t   evt;
   capcomp_mode_t mode = CC_OFF;
   int            n_mismatch = 0, tests_run = 0, t0n = 0, wdn = 0;
   int            a, b, k;
   int            pos [5] = '{0, 1, 2, 2, 6};

   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      t0n <= t0n + int'(t0tick === 1'h1);
      wdn <= wdn + int'(wdtick === 1'h1);
   end

   evt_source_model u_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
      .wdt_run_i(wrun), .t0_ovf_o(t0ovf), .evt_o(evt), .wdt_src_o(wdsrc));

   irq_option_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .external_irq_pin_i(ext[0]), .timer_zero_clock_pin_i(tpin),
      .portb_pins_i(pb), .portb_latch_i(lat), .timer_zero_overflow_i(t0ovf),
      .periph_evt_i(evt), .capcomp_mode_i(mode), .watchdog_src_i(wdsrc),
      .irq_o(irq), .portb_pullup_en_o(pull), .timer_zero_tick_o(t0tick),
      .watchdog_tick_o(wdtick));

   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      if (n_mismatch == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one classic cycle; ack and read data are taken at the same edge
   task automatic wb(logic w, logic [7:0] ad, logic [7:0] d);
      int i;
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      sel <= wsel;
      adr <= ad;
      wdat <= {24'h0, d};
      for (i = 0; i < 50; i++) begin
         @(posedge clk_i);
         if (ack === 1'h1) break;
      end
      rd = dat_o;
      cyc <= 1'h0;
      stb <= 1'h0;
      sel <= 4'h0;
      if (i == 50) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : wb

   task automatic rdc(string nm, logic [7:0] ad, logic [7:0] e);
      wb(1'h0, ad, 8'h00);
      chk(nm, {24'h0, e}, rd);
   endtask : rdc

   task automatic tick(int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   task automatic pulse(logic [5:0] f);
      @(posedge clk_i);
      fire <= f;
      @(posedge clk_i);
      fire <= 6'h00;
      tick(3);
   endtask : pulse

   task automatic irq_is(logic e);
      tick(3);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask : irq_is

   // ticks of both outputs over a window that spans whole periods
   task automatic ticks(int et, int ew);
      tick(300);
      a = t0n;
      b = wdn;
      tick(512);
      chk("t0 ticks", et, t0n - a);
      chk("wdt ticks", ew, wdn - b);
   endtask : ticks

   ////////////////////////////////////////////////////////////////////////
   initial begin
      tick(20);
      rst_i <= 1'h0;
      rdc("option", `OFS_OPTION, 8'hFF);
      rdc("intctl", `OFS_INT_CTRL, 8'h00);
      rdc("pen", `OFS_PERIPH_EN, 8'h00);
      rdc("preq", `OFS_PERIPH_REQ, 8'h00);
      wb(1'h1, 8'h14, 8'hFF);
      rdc("unmapped", 8'h14, 8'h00);
      lat <= 8'hA5;
      wb(1'h1, `OFS_OPTION, 8'h7F);
      tick(2);
      chk("pullups on", 32'hA5, {24'h0, pull});
      wb(1'h1, `OFS_OPTION, 8'hFF);
      tick(2);
      chk("pullups off", 32'h0, {24'h0, pull});
      wsel = 4'hE;
      wb(1'h1, `OFS_OPTION, 8'h00);
      wsel = 4'hF;
      rdc("sel ignored", `OFS_OPTION, 8'hFF);
      wrun <= 1'h1;
      for (k = 0; k < 8; k++) begin
         wb(1'h1, `OFS_OPTION, 8'h80 | k[7:0]);
         ticks(512 >> (k + 1), 512);
         wb(1'h1, `OFS_OPTION, 8'h88 | k[7:0]);
         ticks(512, 512 >> k);
      end
      for (k = 0; k < 2; k++) begin
         wb(1'h1, `OFS_OPTION, 8'hA8 | 8'(k << 4));
         tick(8);
         a = t0n;
         tpin <= 1'h1;
         tick(8);
         chk("pin rise", 1 - k, t0n - a);
         tpin <= 1'h0;
         tick(8);
         chk("pin cycle", 1, t0n - a);
      end
      for (k = 0; k < 2; k++) begin
         wb(1'h1, `OFS_OPTION, 8'h88 | 8'(k << 6));
         wb(1'h1, `OFS_INT_CTRL, 8'h00);
         ext <= 8'h01;
         tick(6);
         rdc("ext rise", `OFS_INT_CTRL, 8'(k << 1));
         ext <= 8'h00;
         tick(6);
         rdc("ext fall", `OFS_INT_CTRL, 8'h02);
      end
      wb(1'h1, `OFS_INT_CTRL, 8'h92);
      irq_is(1'h1);
      wb(1'h1, `OFS_INT_CTRL, 8'h00);
      pb <= 8'h08;
      tick(6);
      rdc("chg off", `OFS_INT_CTRL, 8'h00);
      wb(1'h1, `OFS_PIN_CHG_EN, 8'h08);
      pb <= 8'h00;
      tick(6);
      rdc("chg on", `OFS_INT_CTRL, 8'h01);
      wb(1'h1, `OFS_INT_CTRL, 8'h89);
      irq_is(1'h1);
      wb(1'h1, `OFS_INT_CTRL, 8'h00);
      pulse(6'h20);
      rdc("t0 flag", `OFS_INT_CTRL, 8'h04);
      irq_is(1'h0);
      wb(1'h1, `OFS_INT_CTRL, 8'hA4);
      irq_is(1'h1);
      wb(1'h1, `OFS_INT_CTRL, 8'h24);
      irq_is(1'h0);
      wb(1'h1, `OFS_INT_CTRL, 8'hA0);
      irq_is(1'h0);
      for (k = 0; k < 5; k++) begin
         mode <= k == 3 ? CC_CAPTURE : k == 2 ? CC_COMPARE : CC_PWM;
         pulse(6'(1 << k));
         rdc("periph flag", `OFS_PERIPH_REQ, 8'(1 << pos[k]));
         wb(1'h1, `OFS_PERIPH_REQ, 8'h00);
         mode <= k[0] ? CC_OFF : CC_PWM;
         pulse(6'h0C);
         rdc("pwm idle", `OFS_PERIPH_REQ, 8'h00);
      end
      wb(1'h1, `OFS_INT_CTRL, 8'h80);
      wb(1'h1, `OFS_PERIPH_EN, 8'hFF);
      rdc("pen mask", `OFS_PERIPH_EN, 8'h47);
      wb(1'h1, `OFS_PERIPH_REQ, 8'hFF);
      rdc("preq mask", `OFS_PERIPH_REQ, 8'h47);
      for (k = 0; k < 5; k++) begin
         if (k == 3) continue;
         wb(1'h1, `OFS_PERIPH_REQ, 8'(1 << pos[k]));
         wb(1'h1, `OFS_PERIPH_EN, 8'(1 << pos[k]));
         irq_is(1'h0);
         wb(1'h1, `OFS_INT_CTRL, 8'hC0);
         irq_is(1'h1);
         wb(1'h1, `OFS_PERIPH_EN, 8'h47 & ~8'(1 << pos[k]));
         irq_is(1'h0);
         wb(1'h1, `OFS_INT_CTRL, 8'h80);
      end
      tally_and_finish();
   end
endmodule : tb_irq_option_ctrl
